// >>> design/sdm_pkg.sv
// Constants and types shared by the serial dot-matrix load port.
// Assumes a single 100 MHz system clock; all pins are asynchronous to it.
// Contract
// - Low reset pin clears all control bits
// - Reset leaves dot pattern untouched
// - Rising serial clock shifts data into target
// - Shifting only while chip enable low
// - Cascade output carries serial data onward
// - Target pick low dot, high control
// - Target pick captured at chip enable fall
// - Enable high, clock low: transfer shifted data (a control word waits here while the two-entry buffer is full)
// - Oscillator select: low external, high internal
// - Timebase pin outputs internal, else inputs
// - Dark force high turns LEDs off
// - Sleep stops oscillator and drive current
// - Dot load is 160 or 320 bits
// - Control write is 8 bits, MSB first
// - Top control bit picks which word updates
// - Control word one bit0 sets cascade mode
package sdm_pkg;
	localparam int SDM_CLK_HZ = 100_000_000;
	localparam int SDM_INT_OSC_HZ = 150_000;
	localparam logic [15:0] SDM_OSC_HALF_RST =
		16'(SDM_CLK_HZ / (2 * SDM_INT_OSC_HZ));
	localparam int SDM_DOT_BITS = 160;
	localparam logic [8:0] SDM_CNT_MAX = 9'h140;
	localparam int SDM_CTL_BITS = 8;
	localparam int SDM_CW_BITS = 7;
	localparam logic [4:0] SDM_LAST_COL = 5'h13;
	localparam int SDM_DOT_WORDS = 5;
	// Register offsets
	localparam logic [4:0] SDM_REG_CTRL = 5'h00;
	localparam logic [4:0] SDM_REG_STATUS = 5'h04;
	localparam logic [4:0] SDM_REG_DOT0 = 5'h08;
	// Field positions
	localparam int SDM_CTL_SEL_BIT = 7;
	localparam int SDM_CW0_SLEEP_BIT = 6;
	localparam int SDM_CW0_PEAK_LSB = 4;
	localparam int SDM_CW1_SIMUL_BIT = 0;
	localparam int SDM_CW1_PRESC_BIT = 1;
	localparam int SDM_ST_CW0_LSB = 0;
	localparam int SDM_ST_CW1_LSB = 8;
	localparam int SDM_ST_TGT_BIT = 16;
	localparam int SDM_ST_CNT_LSB = 20;
	localparam logic [2:0] SDM_PRESC_LAST = 3'h7;
	// Pin positions in the synchroniser vector
	localparam int SDM_P_SCLK = 0;
	localparam int SDM_P_DIN = 1;
	localparam int SDM_P_CE_N = 2;
	localparam int SDM_P_PICK = 3;
	localparam int SDM_P_RST_N = 4;
	localparam int SDM_P_SEL = 5;
	localparam int SDM_P_TB = 6;
	localparam int SDM_P_DARK = 7;
	localparam int SDM_PINS = 8;
	typedef enum logic [2:0] {
		SDM_W_IDLE = 3'b001,
		SDM_W_SHIFT = 3'b010,
		SDM_W_LATCH = 3'b100
	} sdm_wstate_t;
endpackage

// >>> design/sdm_buf.sv
// Two-entry buffer for control words leaving the load port.
// Assumes the consumer sits on the same clock as the load port.
`timescale 1ns/100ps
`default_nettype none
module sdm_buf
	import sdm_pkg::*;
(
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [7:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [7:0] out_data_out
);
	logic [7:0] slot0, slot1, next_slot0, next_slot1;
	logic [1:0] cnt, next_cnt;
	logic push, pop;

	assign in_ready_out = (cnt != 2'h2);
	assign out_valid_out = (cnt != 2'h0);
	assign out_data_out = slot0;

	always_comb begin
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		next_slot0 = slot0;
		next_slot1 = slot1;
		next_cnt = cnt;
		if (push && pop) begin
			if (cnt == 2'h1) begin
				next_slot0 = in_data_in;
			end else begin
				next_slot0 = slot1;
				next_slot1 = in_data_in;
			end
		end else if (pop) begin
			next_slot0 = slot1;
			next_cnt = cnt - 2'h1;
		end else if (push) begin
			if (cnt == 2'h0) begin
				next_slot0 = in_data_in;
			end else begin
				next_slot1 = in_data_in;
			end
			next_cnt = cnt + 2'h1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			slot0 <= 8'h00;
			slot1 <= 8'h00;
			cnt <= 2'h0;
		end else begin
			slot0 <= next_slot0;
			slot1 <= next_slot1;
			cnt <= next_cnt;
		end
	end
endmodule
`default_nettype wire

// >>> design/sdm_port.sv
// Serial load port of a dot-matrix LED driver with display refresh.
// Assumes all pins are asynchronous to mclk_in; serial clock is slow.
`timescale 1ns/100ps
`default_nettype none
module sdm_port
	import sdm_pkg::*;
(
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic sclk_in,
	input wire logic din_in,
	input wire logic ce_n_in,
	input wire logic target_pick_in,
	input wire logic rst_n_in,
	input wire logic osc_sel_in,
	input wire logic display_timebase_pin_in,
	output logic display_timebase_pin_out,
	output logic display_timebase_pin_oe_out,
	input wire logic dark_force_in,
	output logic dout_out,
	output logic [7:0] led_row_out,
	output logic [4:0] led_col_out,
	output logic [1:0] peak_level_out,
	output logic ref_current_en_out,
	output logic [7:0] cw_data_out,
	output logic cw_valid_out,
	input wire logic cw_ready_in,
	input wire logic [4:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out
);
	logic [SDM_PINS-1:0] s1, s2, s3;
	sdm_wstate_t state, next_state;
	logic tgt, next_tgt, dout, next_dout;
	logic [7:0] ctl_sr, next_ctl;
	logic [6:0] cw0, cw1, next_cw0, next_cw1;
	logic [8:0] bit_cnt, next_cnt;
	logic [SDM_DOT_BITS-1:0] dot_sr, dot_latch;
	logic dot_shift, dot_load, push, buf_ready;
	logic sclk_s, din_s, ce_s, pick_s, rst_s, sel_s, dark_s;
	logic sclk_rise, ce_fall, tb_rise, awake;
	logic [15:0] osc_half, next_osc_half, int_cnt, next_int_cnt;
	logic int_osc, next_int_osc, tick;
	logic [2:0] pre, next_pre;
	logic [3:0] ph, next_ph;
	logic [4:0] col, next_col;
	logic [7:0] row, next_row;
	logic [31:0] rdata, next_rdata;

	// Two-stage synchronisers for every pin
	genvar g;
	generate
		for (g = 0; g < SDM_PINS; g++) begin : g_sync
			always_ff @(posedge mclk_in) begin
				if (sys_rst_in) begin
					// Enable and reset pins start at their idle high level
					s1[g] <= (g == SDM_P_CE_N) || (g == SDM_P_RST_N);
					s2[g] <= (g == SDM_P_CE_N) || (g == SDM_P_RST_N);
					s3[g] <= (g == SDM_P_CE_N) || (g == SDM_P_RST_N);
				end else begin
					s1[g] <= (g == SDM_P_SCLK) ? sclk_in :
						(g == SDM_P_DIN) ? din_in :
						(g == SDM_P_CE_N) ? ce_n_in :
						(g == SDM_P_PICK) ? target_pick_in :
						(g == SDM_P_RST_N) ? rst_n_in :
						(g == SDM_P_SEL) ? osc_sel_in :
						(g == SDM_P_TB) ? display_timebase_pin_in :
						dark_force_in;
					s2[g] <= s1[g];
					s3[g] <= s2[g];
				end
			end
		end
	endgenerate

	assign sclk_s = s2[SDM_P_SCLK];
	assign din_s = s2[SDM_P_DIN];
	assign ce_s = s2[SDM_P_CE_N];
	assign pick_s = s2[SDM_P_PICK];
	assign rst_s = s2[SDM_P_RST_N];
	assign sel_s = s2[SDM_P_SEL];
	assign dark_s = s2[SDM_P_DARK];
	assign sclk_rise = sclk_s && !s3[SDM_P_SCLK];
	assign ce_fall = !ce_s && s3[SDM_P_CE_N];
	assign tb_rise = s2[SDM_P_TB] && !s3[SDM_P_TB];
	assign awake = cw0[SDM_CW0_SLEEP_BIT];

	// Write sequencer: select, shift, transfer
	always_comb begin
		next_state = state;
		next_tgt = tgt;
		next_ctl = ctl_sr;
		next_cw0 = cw0;
		next_cw1 = cw1;
		next_cnt = bit_cnt;
		dot_shift = 1'b0;
		dot_load = 1'b0;
		push = 1'b0;
		case (state)
			SDM_W_IDLE: begin
				if (ce_fall) begin
					next_tgt = pick_s;
					next_cnt = 9'h000;
					next_state = SDM_W_SHIFT;
				end
			end
			SDM_W_SHIFT: begin
				if (sclk_rise && !ce_s) begin
					if (tgt) begin
						next_ctl = {ctl_sr[SDM_CTL_BITS-2:0], din_s};
					end else begin
						dot_shift = 1'b1;
					end
					if (bit_cnt != SDM_CNT_MAX) begin
						next_cnt = bit_cnt + 9'h001;
					end
				end else if (ce_s) begin
					next_state = SDM_W_LATCH;
				end
			end
			SDM_W_LATCH: begin
				if (ce_fall) begin
					next_tgt = pick_s;
					next_cnt = 9'h000;
					next_state = SDM_W_SHIFT;
				end else if (!sclk_s && (!tgt || buf_ready)) begin
					if (tgt) begin
						if (ctl_sr[SDM_CTL_SEL_BIT]) begin
							next_cw1 = ctl_sr[SDM_CW_BITS-1:0];
						end else begin
							next_cw0 = ctl_sr[SDM_CW_BITS-1:0];
						end
						push = 1'b1;
					end else begin
						dot_load = 1'b1;
					end
					next_state = SDM_W_IDLE;
				end
			end
			default: begin
				next_state = SDM_W_IDLE;
			end
		endcase
		if (!rst_s) begin
			next_cw0 = 7'h00;
			next_cw1 = 7'h00;
			next_ctl = 8'h00;
			push = 1'b0;
		end
		if (!tgt) begin
			next_dout = dot_sr[SDM_DOT_BITS-1];
		end else if (cw1[SDM_CW1_SIMUL_BIT]) begin
			next_dout = din_s;
		end else begin
			next_dout = ctl_sr[SDM_CTL_BITS-1];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			state <= SDM_W_IDLE;
			tgt <= 1'b0;
			ctl_sr <= 8'h00;
			cw0 <= 7'h00;
			cw1 <= 7'h00;
			bit_cnt <= 9'h000;
			dout <= 1'b0;
		end else begin
			state <= next_state;
			tgt <= next_tgt;
			ctl_sr <= next_ctl;
			cw0 <= next_cw0;
			cw1 <= next_cw1;
			bit_cnt <= next_cnt;
			dout <= next_dout;
		end
	end

	// Dot pattern storage has no reset
	always_ff @(posedge mclk_in) begin
		if (dot_shift) begin
			dot_sr <= {dot_sr[SDM_DOT_BITS-2:0], din_s};
		end
		if (dot_load) begin
			dot_latch <= dot_sr;
		end
	end

	sdm_buf u_buf (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.in_valid_in(push),
		.in_ready_out(buf_ready),
		.in_data_in(ctl_sr),
		.out_valid_out(cw_valid_out),
		.out_ready_in(cw_ready_in),
		.out_data_out(cw_data_out)
	);

	// Timebase, prescaler and column scan
	always_comb begin
		next_int_cnt = int_cnt;
		next_int_osc = int_osc;
		next_pre = pre;
		next_ph = ph;
		next_col = col;
		tick = 1'b0;
		if (sel_s && awake) begin
			if (int_cnt >= osc_half - 16'h0001) begin
				next_int_cnt = 16'h0000;
				next_int_osc = !int_osc;
				tick = !int_osc;
			end else begin
				next_int_cnt = int_cnt + 16'h0001;
			end
		end else if (!sel_s && tb_rise) begin
			if (!cw1[SDM_CW1_PRESC_BIT]) begin
				tick = 1'b1;
			end else begin
				next_pre = pre + 3'h1;
				tick = (pre == SDM_PRESC_LAST);
			end
		end
		if (tick) begin
			next_ph = ph + 4'h1;
			if (ph == 4'hf) begin
				next_col = (col == SDM_LAST_COL) ? 5'h00 : col + 5'h01;
			end
		end
		if (awake && !dark_s && ph <= cw0[3:0]) begin
			next_row = dot_latch[{col, 3'b000} +: 8];
		end else begin
			next_row = 8'h00;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			int_cnt <= 16'h0000;
			int_osc <= 1'b0;
			pre <= 3'h0;
			ph <= 4'h0;
			col <= 5'h00;
			row <= 8'h00;
		end else begin
			int_cnt <= next_int_cnt;
			int_osc <= next_int_osc;
			pre <= next_pre;
			ph <= next_ph;
			col <= next_col;
			row <= next_row;
		end
	end

	assign display_timebase_pin_out = int_osc;
	assign display_timebase_pin_oe_out = sel_s;
	assign led_row_out = row;
	assign led_col_out = col;
	assign peak_level_out = cw0[SDM_CW0_PEAK_LSB +: 2];
	assign ref_current_en_out = awake;
	assign dout_out = dout;

	// Register port
	always_comb begin
		next_osc_half = osc_half;
		next_rdata = 32'h0000_0000;
		if (reg_wr_in && reg_addr_in == SDM_REG_CTRL) begin
			next_osc_half = reg_wdata_in[15:0];
		end
		if (reg_rd_in) begin
			if (reg_addr_in == SDM_REG_CTRL) begin
				next_rdata = {16'h0000, osc_half};
			end else if (reg_addr_in == SDM_REG_STATUS) begin
				next_rdata[SDM_ST_CW0_LSB +: 7] = cw0;
				next_rdata[SDM_ST_CW1_LSB +: 7] = cw1;
				next_rdata[SDM_ST_TGT_BIT] = tgt;
				next_rdata[SDM_ST_CNT_LSB +: 9] = bit_cnt;
			end
			for (int i = 0; i < SDM_DOT_WORDS; i++) begin
				if (reg_addr_in == SDM_REG_DOT0 + 5'(4 * i)) begin
					next_rdata = dot_latch[i*32 +: 32];
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			osc_half <= SDM_OSC_HALF_RST;
			rdata <= 32'h0000_0000;
		end else begin
			osc_half <= next_osc_half;
			rdata <= next_rdata;
		end
	end

	assign reg_rdata_out = rdata;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);

	pin_reset_a: assert property (!rst_s |=> cw0 == 7'h00 && cw1 == 7'h00)
		else $error("control words not cleared by reset pin");
	dot_keep_a: assert property (!rst_s && !dot_load |=> $stable(dot_latch))
		else $error("dot latch changed under reset");
	shift_in_a: assert property (dot_shift |=> dot_sr[0] == $past(din_s))
		else $error("dot bit not shifted in");
	ce_hold_a: assert property (ce_s && rst_s |=> $stable(ctl_sr))
		else $error("control shift while enable high");
	pick_cap_a: assert property (ce_fall && state != SDM_W_SHIFT
		|=> tgt == $past(pick_s))
		else $error("target not captured on enable fall");
	dot_xfer_a: assert property (state == SDM_W_LATCH && !tgt && !sclk_s
		&& !ce_fall |=> ##1 dot_latch == $past(dot_sr, 2))
		else $error("dot transfer missing");
	cw_pick_a: assert property (push && ctl_sr[SDM_CTL_SEL_BIT]
		|=> cw1 == $past(ctl_sr[6:0]) && $stable(cw0))
		else $error("wrong control word updated");
	dout_mode_a: assert property (tgt && cw1[SDM_CW1_SIMUL_BIT]
		&& $stable(tgt) |=> dout_out == $past(din_s))
		else $error("simultaneous cascade output wrong");
	tb_dir_a: assert property (!$past(sys_rst_in, 2)
		|-> display_timebase_pin_oe_out == $past(osc_sel_in, 2))
		else $error("timebase pin direction wrong");
	dark_a: assert property (dark_s |=> led_row_out == 8'h00)
		else $error("LEDs lit while dark forced");
	sleep_a: assert property (!awake && sel_s |=> $stable(int_osc))
		else $error("oscillator runs in sleep");

	dot_load_c: cover property (dot_load);
	ctl_load_c: cover property (push ##[1:20] cw_valid_out && cw_ready_in);
	buf_full_c: cover property (state == SDM_W_LATCH && tgt && !buf_ready);
endmodule
`default_nettype wire

// >>> tb/sdm_host_model.sv
// Behavioural host controller driving the serial load pins.
// Assumes the device samples these pins with its own system clock.
`timescale 1ns/100ps
`default_nettype none
module sdm_host_model (
	output var logic sclk_out,
	output var logic din_out,
	output var logic ce_n_out,
	output var logic target_pick_out
);
	initial begin
		sclk_out = 1'b0;
		din_out = 1'b0;
		ce_n_out = 1'b1;
		target_pick_out = 1'b0;
	end

	// Shifts the n low bits of d, MSB first, in one enable frame
	task automatic frame(input logic pick, input logic [159:0] d,
		input int n);
		target_pick_out = pick;
		#125;
		ce_n_out = 1'b0;
		#125;
		// Select moves once its hold time is over
		target_pick_out = ~pick;
		for (int i = n - 1; i >= 0; i--) begin
			din_out = d[i];
			#62 sclk_out = 1'b1;
			#63 sclk_out = 1'b0;
		end
		#62 ce_n_out = 1'b1;
		din_out = ~din_out;
	endtask

	// Clock pulses while the enable is high
	task automatic stray_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			din_out = ~din_out;
			#62 sclk_out = 1'b1;
			#63 sclk_out = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/serial_dot_matrix_load_port_tb.sv
// Self-checking bench for the serial dot-matrix load port.
// Assumes the host model drives the serial pins asynchronously.
`timescale 1ns/100ps
`default_nettype none
module serial_dot_matrix_load_port_tb;
	typedef struct {
		logic [7:0] b;
		logic [6:0] cw0;
		logic [6:0] cw1;
	} sdm_tb_row_t;
	localparam logic [159:0] DOT_PAT =
		160'h0123_4567_89AB_CDEF_F0E1_D2C3_B4A5_9687_7869_5A4B;
	sdm_tb_row_t rows [5] = '{'{8'h5A, 7'h5A, 7'h00},
		'{8'h81, 7'h5A, 7'h01}, '{8'h82, 7'h5A, 7'h02},
		'{8'h00, 7'h00, 7'h02}, '{8'h7F, 7'h7F, 7'h02}};
	logic [7:0] fill [3] = '{8'h11, 8'h22, 8'h33};
	logic mclk_in = 1'b0;
	logic sys_rst_in, rst_n_in, osc_sel_in, dark_force_in, cw_ready_in;
	logic reg_wr_in, reg_rd_in, ext_osc;
	logic [4:0] reg_addr_in;
	logic [31:0] reg_wdata_in, d;
	logic sclk, din, ce_n, pick, tb_out, tb_oe, tb_pin, dout, ref_en;
	logic cw_valid;
	logic [7:0] led_row, cw_data;
	logic [4:0] led_col;
	logic [1:0] peak;
	logic [31:0] rdata;
	logic o0;
	logic [4:0] c0;
	int fail_count = 0;
	int samples_checked = 0;

	initial begin
		forever #5 mclk_in = ~mclk_in;
	end
	always #50 ext_osc = ~ext_osc;
	assign tb_pin = tb_oe ? tb_out : ext_osc;

	sdm_host_model i_host (.sclk_out(sclk), .din_out(din),
		.ce_n_out(ce_n), .target_pick_out(pick));
	sdm_port i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.sclk_in(sclk), .din_in(din), .ce_n_in(ce_n),
		.target_pick_in(pick), .rst_n_in(rst_n_in),
		.osc_sel_in(osc_sel_in), .display_timebase_pin_in(tb_pin),
		.display_timebase_pin_out(tb_out),
		.display_timebase_pin_oe_out(tb_oe),
		.dark_force_in(dark_force_in), .dout_out(dout),
		.led_row_out(led_row), .led_col_out(led_col),
		.peak_level_out(peak), .ref_current_en_out(ref_en),
		.cw_data_out(cw_data), .cw_valid_out(cw_valid),
		.cw_ready_in(cw_ready_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(rdata));

	task automatic summarize;
		$display("Checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic pop(input logic [7:0] exp);
		int i;
		for (i = 0; i < 400 && cw_valid !== 1'b1; i++) begin
			@(posedge mclk_in);
			#1;
		end
		if (i == 400) begin
			fail_count++;
			summarize();
		end
		chk("cw_data", 32'(cw_data), 32'(exp));
		@(posedge mclk_in);
		cw_ready_in <= 1'b1;
		@(posedge mclk_in);
		cw_ready_in <= 1'b0;
		#1;
	endtask

	task automatic chk_dots;
		for (int k = 0; k < 5; k++) begin
			rd(5'h08 + 5'(4 * k));
			chk("dot", d, DOT_PAT[32 * k +: 32]);
		end
	endtask

	initial begin
		{sys_rst_in, rst_n_in, osc_sel_in} = 3'b111;
		{dark_force_in, cw_ready_in, reg_wr_in, reg_rd_in, ext_osc} = 5'h00;
		reg_addr_in = 5'h00;
		reg_wdata_in = 32'h0000_0000;
		repeat (12) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		wr(5'h00, 32'h0000_0004);
		rd(5'h00);
		chk("osc_half", d, 32'h0000_0004);
		rd(5'h1C);
		chk("unmapped", d, 32'h0000_0000);
		i_host.frame(1'b0, DOT_PAT, 160);
		repeat (10) @(posedge mclk_in);
		chk("dout", 32'(dout), 32'(DOT_PAT[159]));
		chk_dots();
		i_host.stray_clocks(4);
		repeat (10) @(posedge mclk_in);
		chk_dots();
		rd(5'h04);
		chk("count", 32'(d[28:20]), 32'h0000_00A0);
		foreach (rows[r]) begin
			i_host.frame(1'b1, {152'h0, rows[r].b}, 8);
			pop(rows[r].b);
			rd(5'h04);
			chk("cw0", 32'(d[6:0]), 32'(rows[r].cw0));
			chk("cw1", 32'(d[14:8]), 32'(rows[r].cw1));
			chk("target", 32'(d[16]), 32'h1);
			chk("ref_en", 32'(ref_en), 32'(rows[r].cw0[6]));
			chk("peak", 32'(peak), 32'(rows[r].cw0[5:4]));
		end
		repeat (40) @(posedge mclk_in);
		chk("lit", 32'(led_row != 8'h00), 32'h1);
		#1;
		o0 = tb_out;
		repeat (4) @(posedge mclk_in);
		#1;
		chk("osc_out", 32'(tb_out), 32'(!o0));
		@(posedge mclk_in);
		dark_force_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		chk("dark", 32'(led_row), 32'h0);
		dark_force_in <= 1'b0;
		osc_sel_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
		chk("oe_ext", 32'(tb_oe), 32'h0);
		#1;
		c0 = led_col;
		repeat (2560) @(posedge mclk_in);
		#1;
		chk("col_pre8", 32'(led_col), (32'(c0) + 32'h0000_0002) % 32'h0000_0014);
		i_host.frame(1'b1, {152'h0, 8'h80}, 8);
		pop(8'h80);
		c0 = led_col;
		repeat (1600) @(posedge mclk_in);
		#1;
		chk("col_pre1", 32'(led_col), (32'(c0) + 32'h0000_000A) % 32'h0000_0014);
		@(posedge mclk_in);
		osc_sel_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		chk("oe_int", 32'(tb_oe), 32'h1);
		rst_n_in <= 1'b0;
		repeat (5) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		repeat (5) @(posedge mclk_in);
		rd(5'h04);
		chk("cw_clear", 32'({d[14:8], d[6:0]}), 32'h0);
		chk("ref_off", 32'(ref_en), 32'h0);
		o0 = tb_out;
		repeat (8) @(posedge mclk_in);
		#1;
		chk("osc_sleep", 32'(tb_out), 32'(o0));
		chk_dots();
		foreach (fill[k]) begin
			i_host.frame(1'b1, {152'h0, fill[k]}, 8);
		end
		chk("full", 32'(cw_valid), 32'h1);
		repeat (20) @(posedge mclk_in);
		rd(5'h04);
		chk("stall", 32'(d[6:0]), 32'h0000_0022);
		foreach (fill[k]) begin
			pop(fill[k]);
		end
		repeat (10) @(posedge mclk_in);
		chk("empty", 32'(cw_valid), 32'h0);
		rd(5'h04);
		chk("cw0_last", 32'(d[6:0]), 32'h0000_0033);
		summarize();
	end
endmodule
`default_nettype wire
